//--- hwpc_pkg.sv
// Purpose: Shared constants and types for the haptic playback control block
// Assumes: 250 MHz system clock, 8-bit register port
// Notes: Every offset, field position, reset value and count lives here
package hwpc_pkg;

  // Register offsets
  localparam logic [7:0] OFS_MODE = 8'h01;
  localparam logic [7:0] OFS_RTP = 8'h02;
  localparam logic [7:0] OFS_SEQ_FIRST = 8'h04;
  localparam logic [7:0] OFS_SEQ_LAST = 8'h0b;
  localparam logic [7:0] OFS_GO = 8'h0c;
  localparam logic [7:0] OFS_AMAX = 8'h13;
  localparam logic [7:0] OFS_RATED = 8'h16;
  localparam logic [7:0] OFS_CLAMP = 8'h17;
  localparam logic [7:0] OFS_CTL1B = 8'h1b;
  localparam logic [7:0] OFS_CTL1C = 8'h1c;
  localparam logic [7:0] OFS_CTL1D = 8'h1d;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // Field positions
  localparam int STBY_BIT = 6;
  localparam int DEVRST_BIT = 7;
  localparam int GO_BIT = 0;
  localparam int WAIT_BIT = 7;
  localparam int ACCPL_BIT = 5;
  localparam int BIDIR_BIT = 7;
  localparam int FMT_BIT = 3;
  localparam int PWMAN_BIT = 1;

  // Reset values
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic RST_STBY = 1'b1;
  localparam logic [7:0] RST_SEQ0 = 8'h01;
  localparam logic [7:0] RST_AMAX = 8'hff;
  localparam logic [7:0] RST_RATED = 8'h3f;
  localparam logic [7:0] RST_CLAMP = 8'h89;
  localparam logic [7:0] RST_CTL1B = 8'h93;
  localparam logic [7:0] RST_CTL1C = 8'hf5;
  localparam logic [7:0] RST_CTL1D = 8'ha0;

  // Mode field encodings
  localparam logic [2:0] MODE_INT = 3'h0;
  localparam logic [2:0] MODE_EDGE = 3'h1;
  localparam logic [2:0] MODE_LEVEL = 3'h2;
  localparam logic [2:0] MODE_PWMAN = 3'h3;
  localparam logic [2:0] MODE_AUDIO = 3'h4;
  localparam logic [2:0] MODE_RTP = 3'h5;

  // Data constants
  localparam logic [7:0] MID_SCALE = 8'h80;
  localparam logic [6:0] ID_MAX = 7'h7b;
  localparam logic [2:0] LAST_IDX = 3'h7;

  // Timing
  localparam int CLK_MHZ = 250;
  localparam int WAIT_UNIT_MS = 10;
  localparam int WAIT_UNIT_CYC = WAIT_UNIT_MS * CLK_MHZ * 1000;
  localparam logic [7:0] PWM_WIN_LAST = 8'hff;

  // Sequencer states
  typedef enum logic [1:0] {SQ_IDLE, SQ_LOAD, SQ_PLAY, SQ_WAIT} hwpc_seq_e;

endpackage

//--- hwpc_pin_meter.sv
// Purpose: Synchronise the input/trigger pin, find its rising edges, measure duty
// Assumes: Pin is asynchronous to clk_sys and slower than a few cycles
// Notes: Duty is the count of high samples over a 256-cycle window
`timescale 1ns/1ps
module hwpc_pin_meter
  import hwpc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic pinRaw,
  output logic pinLevel,
  output logic pinRise,
  output logic [7:0] dutyLevel
);

  typedef struct packed {
    logic s0; // First synchroniser stage
    logic s1; // Second synchroniser stage
    logic s2; // Delayed copy for edge detection
    logic rise; // Registered rising edge
    logic [7:0] winCnt; // Position in window
    logic [8:0] hiCnt; // High samples so far
    logic [7:0] duty; // Last completed duty
  } hwpc_meter_s;

  hwpc_meter_s st_q;
  hwpc_meter_s st_d;
  logic [8:0] hiNext;

  // Next-state logic
  always_comb
  begin
    st_d = st_q;
    st_d.s0 = pinRaw;
    st_d.s1 = st_q.s0;
    st_d.s2 = st_q.s1;
    st_d.rise = st_q.s1 & ~st_q.s2;
    st_d.winCnt = st_q.winCnt + 8'h01;
    hiNext = st_q.hiCnt + {8'h00, st_q.s1};
    if (st_q.winCnt == PWM_WIN_LAST)
    begin
      // Full window: 256 highs saturate to full scale
      st_d.duty = hiNext[8] ? 8'hff : hiNext[7:0];
      st_d.hiCnt = 9'h000;
    end
    else
    begin
      st_d.hiCnt = hiNext;
    end
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign pinLevel = st_q.s1;
  assign pinRise = st_q.rise;
  assign dutyLevel = st_q.duty;

endmodule // hwpc_pin_meter

//--- hwpc_top.sv
// Purpose: Playback control: source select, closed-loop mapping, sequencer
// Assumes: Register port with read data one cycle after the read strobe
// Notes: ROM engine and output stage sit outside, on clk_sys
// Summary of operation
// - Below mid-scale input gives zero drive in bidirectional mode unless braking, except in audio mode
// - Rated sets full scale, clamp bounds output
// - Brake when back-EMF feedback asks for it, in bidirectional mode only
// - Bidirectional closed loop is the reset default
// - Realtime amplitude 8 bits, signed or unsigned
// - Mode 5 drives from realtime amplitude register
// - Mode 3 with analog select uses pin voltage
// - Analog or PWM drive runs until standby/mode
// - Analog voltage maps linearly to duty percentage
// - Mode 3 without analog select measures PWM duty
// - Audio needs mode 4, coupling and analog bits
// - Audio full scale reduced by maximum input
// - Eight entries, identifiers 1 to 123
// - Go starts playback at first entry
// - Advance on non-zero, stop at zero or eighth; a non-wait id above 123 also stops
// - MSB entry waits low bits times 10 ms
// - Modes 0/1/2: go, edge, level trigger
`timescale 1ns/1ps
module hwpc_top
  import hwpc_pkg::*;
#(
  parameter int WAIT_CYC = WAIT_UNIT_CYC // Cycles in one 10 ms wait unit
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic input_trigger_pin,
  input wire logic [7:0] adcLevel,
  input wire logic bemfBrake,
  input wire logic [7:0] romLevel,
  input wire logic romDone,
  output logic [7:0] driveLevel,
  output logic driveBrake,
  output logic driveActive,
  output logic romStart,
  output logic [6:0] romId
);

  typedef struct packed {
    logic [2:0] mode; // Interface mode field
    logic stby; // Standby
    logic [7:0] realtime_amplitude_value; // Streamed amplitude
    logic [7:0][7:0] seq; // Sequencer entries
    logic go; // Go bit
    logic [7:0] audio_input_fullscale; // Audio maximum input
    logic [7:0] rated; // Rated level
    logic [7:0] overdrive_limit_level; // Clamp level
    logic [7:0] ctl1b; // Holds coupling enable
    logic [7:0] ctl1c; // Holds bidirectional select
    logic [7:0] ctl1d; // Holds format and analog select
    logic [7:0] rdData; // Read data
    hwpc_seq_e state; // Sequencer state
    logic [2:0] idx; // Current entry
    logic [6:0] waitCnt; // Wait units left
    logic [21:0] unitCnt; // Cycles within a unit
    logic romStart; // Waveform start pulse
    logic [6:0] romId; // Waveform identifier
    logic [7:0] adcS0; // Analog code, stage one
    logic [7:0] adcS1; // Analog code, stage two
    logic bemfS0; // Feedback, stage one
    logic bemfS1; // Feedback, stage two
    logic [7:0] lvl; // Drive level
    logic brake; // Brake request
    logic active; // Drive active
  } hwpc_state_s;

  hwpc_state_s st_q;
  hwpc_state_s st_d;

  logic pinLevel; // Synchronised pin level
  logic pinRise; // Pin rising edge
  logic [7:0] dutyLevel; // Measured PWM duty

  // Comb temporaries
  logic goWr;
  logic startReq;
  logic stepDone;
  logic finish;
  logic [7:0] entry;
  logic [7:0] raw;
  logic [7:0] mag;
  logic direct;
  logic srcOn;
  logic [7:0] aMag;
  logic [15:0] aShift;
  logic [15:0] prod;
  logic [7:0] scaled;

  // Pin synchroniser, edge finder and duty meter
  hwpc_pin_meter uMeter (
    .clk_sys(clk_sys),
    .srst(srst),
    .pinRaw(input_trigger_pin),
    .pinLevel(pinLevel),
    .pinRise(pinRise),
    .dutyLevel(dutyLevel)
  );

  // Sequencer entry address decode, shared by read and write
  function automatic logic isSeq(input logic [7:0] a);
    isSeq = (a >= OFS_SEQ_FIRST) && (a <= OFS_SEQ_LAST);
  endfunction

  // Gain shift for audio: leading zeros of the maximum-input setting
  function automatic logic [2:0] gainShift(input logic [7:0] m);
    gainShift = 3'h0;
    for (int i = 0; i < 8; i++)
      if (m[i])
        gainShift = 3'(7 - i);
  endfunction

  // Defaults after reset or software device reset
  function automatic hwpc_state_s defaults();
    hwpc_state_s d;
    d = '0;
    d.mode = RST_MODE;
    d.stby = RST_STBY;
    d.seq[0] = RST_SEQ0;
    d.audio_input_fullscale = RST_AMAX;
    d.rated = RST_RATED;
    d.overdrive_limit_level = RST_CLAMP;
    d.ctl1b = RST_CTL1B;
    d.ctl1c = RST_CTL1C;
    d.ctl1d = RST_CTL1D;
    d.state = SQ_IDLE;
    defaults = d;
  endfunction

  // Next-state logic: register port, sequencer, drive mapping
  always_comb
  begin
    st_d = st_q;
    st_d.romStart = 1'b0;
    // Two-stage synchronisers for outside signals
    st_d.adcS0 = adcLevel;
    st_d.adcS1 = st_q.adcS0;
    st_d.bemfS0 = bemfBrake;
    st_d.bemfS1 = st_q.bemfS0;

    // Read path: unmapped offsets read as zero
    st_d.rdData = 8'h00;
    if (regRd)
    begin
      case (regAddr)
        OFS_MODE: st_d.rdData = {1'b0, st_q.stby, 3'h0, st_q.mode};
        OFS_RTP: st_d.rdData = st_q.realtime_amplitude_value;
        OFS_GO: st_d.rdData = {7'h00, st_q.go};
        OFS_AMAX: st_d.rdData = st_q.audio_input_fullscale;
        OFS_RATED: st_d.rdData = st_q.rated;
        OFS_CLAMP: st_d.rdData = st_q.overdrive_limit_level;
        OFS_CTL1B: st_d.rdData = st_q.ctl1b;
        OFS_CTL1C: st_d.rdData = st_q.ctl1c;
        OFS_CTL1D: st_d.rdData = st_q.ctl1d;
        OFS_STATUS: st_d.rdData = {5'h00, st_q.brake, st_q.active,
                                   st_q.state != SQ_IDLE};
        default:
          if (isSeq(regAddr))
            st_d.rdData = st_q.seq[3'(regAddr - OFS_SEQ_FIRST)];
      endcase
    end

    // Write path
    goWr = regWr && (regAddr == OFS_GO);
    if (regWr)
    begin
      case (regAddr)
        OFS_MODE:
        begin
          st_d.mode = regWrData[2:0];
          st_d.stby = regWrData[STBY_BIT];
        end
        OFS_RTP: st_d.realtime_amplitude_value = regWrData;
        OFS_GO: st_d.go = regWrData[GO_BIT];
        OFS_AMAX: st_d.audio_input_fullscale = regWrData;
        OFS_RATED: st_d.rated = regWrData;
        OFS_CLAMP: st_d.overdrive_limit_level = regWrData;
        OFS_CTL1B: st_d.ctl1b = regWrData;
        OFS_CTL1C: st_d.ctl1c = regWrData;
        OFS_CTL1D: st_d.ctl1d = regWrData;
        default:
          if (isSeq(regAddr))
            st_d.seq[3'(regAddr - OFS_SEQ_FIRST)] = regWrData;
      endcase
    end

    // Trigger source by mode
    startReq = ((st_q.mode == MODE_INT) && st_q.go) ||
               ((st_q.mode == MODE_EDGE) && pinRise) ||
               ((st_q.mode == MODE_LEVEL) && pinLevel);

    // Sequencer
    stepDone = 1'b0;
    finish = 1'b0;
    entry = st_q.seq[st_q.idx];
    case (st_q.state)
      SQ_IDLE:
        if (startReq && !st_q.stby)
        begin
          // Entries are taken as loaded; the host fills them first
          st_d.go = 1'b1;
          st_d.idx = 3'h0;
          st_d.state = SQ_LOAD;
        end
      SQ_LOAD:
        if (entry == 8'h00)
          finish = 1'b1;
        else if (entry[WAIT_BIT])
        begin
          st_d.waitCnt = entry[6:0];
          st_d.unitCnt = 22'h000000;
          st_d.state = SQ_WAIT;
        end
        else if (entry[6:0] > ID_MAX)
          finish = 1'b1;
        else
        begin
          st_d.romStart = 1'b1;
          st_d.romId = entry[6:0];
          st_d.state = SQ_PLAY;
        end
      SQ_PLAY:
        if (romDone)
          stepDone = 1'b1;
      SQ_WAIT:
        if (st_q.waitCnt == 7'h00)
          stepDone = 1'b1;
        else if (st_q.unitCnt == 22'(WAIT_CYC - 1))
        begin
          st_d.unitCnt = 22'h000000;
          st_d.waitCnt = st_q.waitCnt - 7'h01;
        end
        else
          st_d.unitCnt = st_q.unitCnt + 22'h000001;
      default: st_d.state = SQ_IDLE;
    endcase
    if (stepDone)
    begin
      if (st_q.idx == LAST_IDX)
        finish = 1'b1;
      else
      begin
        st_d.idx = st_q.idx + 3'h1;
        st_d.state = SQ_LOAD;
      end
    end
    // Host abort: standby, or go cleared by software while playing
    if ((st_q.state != SQ_IDLE) &&
        (st_q.stby || (goWr && !regWrData[GO_BIT])))
      finish = 1'b1;
    if (finish)
    begin
      st_d.state = SQ_IDLE;
      // A go write of one in the same cycle wins over the clear
      st_d.go = goWr && regWrData[GO_BIT];
    end

    // Source select; raw is offset binary with mid-scale as zero, except the audio magnitude
    raw = MID_SCALE;
    direct = 1'b0;
    srcOn = 1'b0;
    aMag = st_q.adcS1[7] ? {st_q.adcS1[6:0], 1'b0} :
                           {~st_q.adcS1[6:0], 1'b0};
    aShift = {8'h00, aMag} << gainShift(st_q.audio_input_fullscale);
    case (st_q.mode)
      MODE_RTP:
      begin
        srcOn = 1'b1;
        raw = st_q.ctl1d[FMT_BIT] ? st_q.realtime_amplitude_value :
              (st_q.realtime_amplitude_value ^ MID_SCALE);
      end
      MODE_PWMAN:
      begin
        srcOn = 1'b1;
        // Analog code 0..255 spans 0..1.8 V as a duty percentage
        raw = st_q.ctl1d[PWMAN_BIT] ? st_q.adcS1 : dutyLevel;
      end
      MODE_AUDIO:
        if (st_q.ctl1b[ACCPL_BIT] && st_q.ctl1d[PWMAN_BIT])
        begin
          srcOn = 1'b1;
          direct = 1'b1;
          // Power-of-two gain only: smaller sources get coarse scaling
          raw = (aShift[15:8] != 8'h00) ? 8'hff : aShift[7:0];
        end
      MODE_INT, MODE_EDGE, MODE_LEVEL:
        if (st_q.state == SQ_PLAY)
        begin
          srcOn = 1'b1;
          raw = romLevel;
        end
      default: srcOn = 1'b0;
    endcase

    // Closed-loop mapping
    if (direct || !st_q.ctl1c[BIDIR_BIT])
      mag = raw;
    else if (raw < MID_SCALE)
      mag = 8'h00;
    else
      mag = {raw[6:0], 1'b0};
    prod = mag * st_q.rated;
    scaled = prod[15:8];
    st_d.active = srcOn && !st_q.stby;
    st_d.brake = st_d.active && st_q.bemfS1 &&
                 st_q.ctl1c[BIDIR_BIT];
    if (!st_d.active)
      st_d.lvl = 8'h00;
    else if (st_d.brake || (scaled > st_q.overdrive_limit_level))
      st_d.lvl = st_q.overdrive_limit_level;
    else
      st_d.lvl = scaled;

    // Software device reset restores defaults
    if (regWr && (regAddr == OFS_MODE) && regWrData[DEVRST_BIT])
      st_d = defaults();
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      st_q <= defaults();
    else
      st_q <= st_d;
  end

  assign regRdData = st_q.rdData;
  assign driveLevel = st_q.lvl;
  assign driveBrake = st_q.brake;
  assign driveActive = st_q.active;
  assign romStart = st_q.romStart;
  assign romId = st_q.romId;

  a_mid_zero: assert property (@(posedge clk_sys) disable iff (srst)
    (st_q.mode == MODE_RTP) && st_q.ctl1c[BIDIR_BIT] && st_q.ctl1d[FMT_BIT]
    && (st_q.realtime_amplitude_value < MID_SCALE) && !st_q.bemfS1
    && !regWr |=> (st_q.lvl == 8'h00))
    else $error("Below mid-scale input produced drive");

  a_clamp_bound: assert property (@(posedge clk_sys) disable iff (srst)
    1'b1 |=> (st_q.lvl <= $past(st_q.overdrive_limit_level)))
    else $error("Drive level above clamp");

  a_brake_cause: assert property (@(posedge clk_sys) disable iff (srst)
    st_q.brake |-> $past(st_q.bemfS1))
    else $error("Brake without feedback request");

  a_reset_bidir: assert property (@(posedge clk_sys)
    $past(srst) && !srst |-> st_q.ctl1c[BIDIR_BIT] && st_q.stby)
    else $error("Not bidirectional after reset");

  a_signed_zero: assert property (@(posedge clk_sys) disable iff (srst)
    (st_q.mode == MODE_RTP) && !st_q.ctl1d[FMT_BIT] && !st_q.bemfS1
    && (st_q.realtime_amplitude_value == 8'h00) && !regWr
    |=> (st_q.lvl == 8'h00))
    else $error("Signed zero amplitude produced drive");

  a_rtp_active: assert property (@(posedge clk_sys) disable iff (srst)
    (st_q.mode == MODE_RTP) && !st_q.stby && !regWr |=> st_q.active)
    else $error("Realtime mode not driving");

  a_audio_gate: assert property (@(posedge clk_sys) disable iff (srst)
    st_q.active && (st_q.mode == MODE_AUDIO) && !$past(regWr)
    |-> st_q.ctl1b[ACCPL_BIT] && st_q.ctl1d[PWMAN_BIT])
    else $error("Audio drive without enables");

  a_seq_start: assert property (@(posedge clk_sys) disable iff (srst)
    (st_q.state == SQ_IDLE) && startReq && !st_q.stby && !regWr
    |=> (st_q.state == SQ_LOAD) && (st_q.idx == 3'h0) && st_q.go)
    else $error("Sequencer did not start at first entry");

  a_zero_stop: assert property (@(posedge clk_sys) disable iff (srst)
    (st_q.state == SQ_LOAD) && (entry == 8'h00) && !regWr
    |=> (st_q.state == SQ_IDLE) && !st_q.go)
    else $error("Zero entry did not end playback");

  a_wait_load: assert property (@(posedge clk_sys) disable iff (srst)
    (st_q.state == SQ_LOAD) && entry[WAIT_BIT] && !st_q.stby && !regWr
    |=> (st_q.state == SQ_WAIT) && (st_q.waitCnt == $past(entry[6:0])))
    else $error("Wait entry not loaded");

endmodule // hwpc_top

//--- hwpc_rom_model.sv
// Purpose: ROM waveform engine stand-in on the far side of the sequencer
// Assumes: Same clock as the block; one waveform at a time
// Notes: Bench sets the finish delay to act prompt or slow (min 1)
`timescale 1ns/1ps
module hwpc_rom_model
  import hwpc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic romStart,
  input wire logic [7:0] doneDelay,
  output logic [7:0] romLevel = 8'h80,
  output logic romDone = 1'b0
);
  int cnt = 0; // Cycles left in the running waveform

  // One waveform per start, then a single done pulse
  always @(posedge clk_sys)
  begin
    // Done is a one-cycle pulse when the countdown reaches its end
    romDone <= !srst && !romStart && (cnt == 1);
    if (srst)
    begin
      cnt <= 0;
      romLevel <= MID_SCALE;
    end
    else if (romStart)
    begin
      // A restart simply reloads the delay
      cnt <= int'(doneDelay);
      romLevel <= 8'hc0;
    end
    else if (cnt == 1)
    begin
      cnt <= 0;
      romLevel <= MID_SCALE;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule // hwpc_rom_model

//--- tb_hwpc_top.sv
// Purpose: Self-checking bench for the haptic playback control block
// Assumes: 250 MHz clock, short wait unit, ROM model on the far side
// Notes: Levels use rated 0x80 and clamp 0xff unless a test says else
`timescale 1ns/1ps
module tb_hwpc_top
  import hwpc_pkg::*;
();
  localparam int WCYC = 20; // Short wait unit keeps the run brief
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData;
  logic input_trigger_pin = 1'b0; // Also the 64 ns PWM link
  logic [7:0] adcLevel = 8'h80;
  logic bemfBrake = 1'b0;
  logic [7:0] romLevel;
  logic romDone;
  logic [7:0] driveLevel;
  logic driveBrake;
  logic driveActive;
  logic romStart;
  logic [6:0] romId;
  logic [7:0] doneDelay = 8'h04; // ROM model speed
  logic pwmOn = 1'b0; // PWM frames run only while set
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [6:0] ids[$]; // Waveform ids seen at each start
  int starts[$]; // Cycle stamp of each start
  logic [7:0] rstA[10] = '{OFS_MODE, OFS_RTP, OFS_SEQ_FIRST, OFS_GO,
    OFS_AMAX, OFS_RATED, OFS_CLAMP, OFS_CTL1B, OFS_CTL1C, 8'h03};
  logic [7:0] rstV[10] = '{8'h40, 8'h00, 8'h01, 8'h00, 8'hff, 8'h3f,
    8'h89, 8'h93, 8'hf5, 8'h00};

  hwpc_top #(.WAIT_CYC(WCYC)) i_hwpc_top (.clk_sys(clk_sys), .srst(srst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData),
    .input_trigger_pin(input_trigger_pin), .adcLevel(adcLevel),
    .bemfBrake(bemfBrake), .romLevel(romLevel), .romDone(romDone),
    .driveLevel(driveLevel), .driveBrake(driveBrake),
    .driveActive(driveActive), .romStart(romStart), .romId(romId));

  hwpc_rom_model i_hwpc_rom_model (.clk_sys(clk_sys), .srst(srst),
    .romStart(romStart), .doneDelay(doneDelay), .romLevel(romLevel),
    .romDone(romDone));

  initial forever #2 clk_sys = ~clk_sys;

  // Logs every waveform start with its cycle stamp
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (romStart === 1'b1)
    begin
      ids.push_back(romId);
      starts.push_back(cyc);
    end
  end

  // Link pin, 3/4 high, stands low between frames
  always
  begin
    wait (pwmOn);
    #1 input_trigger_pin <= 1'b1;
    #48 input_trigger_pin <= 1'b0;
    #15;
  end

  task automatic chk(input string nm, input logic [7:0] seen,
    input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  // Read data is taken just after the edge that registers it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk($sformatf("reg %h", a), d, exp);
  endtask

  // Lets sync flops and the drive pipeline settle before looking
  task automatic drv(input logic [7:0] lvl, input logic act);
    repeat (8) @(posedge clk_sys);
    #1;
    chk("level", driveLevel, lvl);
    chk("active", {7'h00, driveActive}, {7'h00, act});
  endtask

  // Polls go until it drops, bounded so a stuck bit cannot hang
  task automatic waitGo();
    logic [7:0] d;
    int n;
    d = 8'h01;
    n = 0;
    while (d !== 8'h00 && n < 500)
    begin
      rd(OFS_GO, d);
      n++;
    end
    chk("go", d, 8'h00);
  endtask

  task automatic seqChk(input logic [6:0] exp[$]);
    chk("count", 8'(ids.size()), 8'(exp.size()));
    foreach (exp[i])
      chk("id", {1'b0, ids[i]}, {1'b0, exp[i]});
    ids.delete();
    starts.delete();
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog: far beyond the few thousand cycles the tests need
  initial
  begin
    #200000;
    error_cnt++;
    close_out();
  end

  initial
  begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    foreach (rstA[i]) rdc(rstA[i], rstV[i]);
    // Realtime amplitude, unsigned then signed
    wr(OFS_RATED, 8'h80);
    wr(OFS_CLAMP, 8'hff);
    wr(OFS_CTL1D, 8'ha8);
    wr(OFS_RTP, 8'h40);
    wr(OFS_MODE, MODE_RTP);
    drv(8'h00, 1'b1);
    wr(OFS_RTP, 8'hc0);
    drv(8'h40, 1'b1);
    wr(OFS_CTL1D, 8'ha0);
    drv(8'h00, 1'b1);
    wr(OFS_RTP, 8'h40);
    drv(8'h40, 1'b1);
    // Clamp bounds the output, brake drives at the clamp
    wr(OFS_RATED, 8'hff);
    wr(OFS_CLAMP, 8'h30);
    wr(OFS_RTP, 8'h7f);
    drv(8'h30, 1'b1);
    wr(OFS_CLAMP, 8'h60);
    wr(OFS_RTP, 8'h00);
    bemfBrake <= 1'b1;
    drv(8'h60, 1'b1);
    chk("brake", {7'h00, driveBrake}, 8'h01);
    bemfBrake <= 1'b0;
    wr(OFS_RATED, 8'h80);
    wr(OFS_CLAMP, 8'hff);
    wr(OFS_MODE, 8'h45);
    drv(8'h00, 1'b0);
    // Analog input through the closed-loop mapping
    adcLevel <= 8'hc0;
    wr(OFS_CTL1D, 8'ha2);
    wr(OFS_MODE, MODE_PWMAN);
    drv(8'h40, 1'b1);
    adcLevel <= 8'hff;
    repeat (300) @(posedge clk_sys);
    drv(8'h7f, 1'b1);
    // PWM duty of 3/4 on the link pin
    wr(OFS_CTL1D, 8'ha0);
    pwmOn <= 1'b1;
    repeat (900) @(posedge clk_sys);
    #1;
    chk("pwm", {7'h00, driveLevel inside {[8'h3f:8'h41]}}, 8'h01);
    pwmOn <= 1'b0;
    // Audio needs coupling and analog select both set
    adcLevel <= 8'hc0;
    wr(OFS_CTL1D, 8'ha2);
    wr(OFS_MODE, MODE_AUDIO);
    drv(8'h00, 1'b0);
    wr(OFS_CTL1B, 8'hb3);
    drv(8'h40, 1'b1);
    wr(OFS_AMAX, 8'h3f);
    drv(8'h7f, 1'b1);
    // Sequencer: wait step, top id, out-of-range id ends it
    wr(OFS_MODE, MODE_INT);
    wr(OFS_SEQ_FIRST, 8'h05);
    wr(OFS_SEQ_FIRST + 8'h01, 8'h83);
    wr(OFS_SEQ_FIRST + 8'h02, 8'h7b);
    wr(OFS_SEQ_FIRST + 8'h03, 8'h7c);
    wr(OFS_GO, 8'h01);
    waitGo();
    chk("gap", {7'h00, (starts[1] - starts[0]) inside {[64:90]}}, 8'h01);
    seqChk('{7'h05, 7'h7b});
    // All eight entries full, slow ROM
    doneDelay <= 8'd30;
    for (int i = 0; i < 8; i++)
      wr(OFS_SEQ_FIRST + 8'(i), 8'(i + 1));
    wr(OFS_GO, 8'h01);
    // Mid-waveform: ROM level 0xc0 at rated 0x80 gives 0x40
    repeat (10) @(posedge clk_sys);
    #1;
    chk("rom level", driveLevel, 8'h40);
    rdc(OFS_STATUS, 8'h03);
    waitGo();
    seqChk('{1, 2, 3, 4, 5, 6, 7, 8});
    // Edge trigger: nothing until the pin rises
    doneDelay <= 8'd4;
    wr(OFS_SEQ_FIRST, 8'h09);
    wr(OFS_SEQ_FIRST + 8'h01, 8'h00);
    wr(OFS_MODE, MODE_EDGE);
    repeat (20) @(posedge clk_sys);
    chk("idle", 8'(ids.size()), 8'h00);
    input_trigger_pin <= 1'b1;
    repeat (40) @(posedge clk_sys);
    input_trigger_pin <= 1'b0;
    waitGo();
    seqChk('{7'h09});
    // Level trigger: drop the pin once playback starts
    wr(OFS_MODE, MODE_LEVEL);
    input_trigger_pin <= 1'b1;
    repeat (40)
      if (ids.size() == 0) @(posedge clk_sys);
    input_trigger_pin <= 1'b0;
    waitGo();
    seqChk('{7'h09});
    // Software reset restores the power-up defaults
    wr(OFS_MODE, 8'h80);
    rdc(OFS_MODE, 8'h40);
    rdc(OFS_CTL1C, 8'hf5);
    close_out();
  end
endmodule // tb_hwpc_top
